// *** src/iss_irq.sv ***
// Sticky interrupt status with enable and write-one clear
`timescale 1ns/1ps
module iss_irq
    import iss_pkg::*;
#(
    parameter int W = IRQ_W
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Events and software access
    input wire logic [W-1:0] evt,
    input wire logic [W-1:0] clr,
    input wire logic en_we,
    input wire logic [W-1:0] en_wdat,
    // State
    output logic [W-1:0] status,
    output logic [W-1:0] enable,
    output logic irq
);

    typedef struct packed {
        logic [W-1:0] st;
        logic [W-1:0] en;
    } iss_irq_st_t;

    iss_irq_st_t s_r;
    iss_irq_st_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        // Set wins over a clear in the same cycle
        s_nxt.st = (s_r.st & ~clr) | evt;
        if (en_we)
            s_nxt.en = en_wdat;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign status = s_r.st;
    assign enable = s_r.en;
    assign irq = |(s_r.st & s_r.en);

endmodule

// *** src/iss_pkg.sv ***
// Register map, field layout and state codes of the status/SCL block
package iss_pkg;

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'hD8;
    localparam logic [7:0] ADDR_STATUS = 8'hD9;
    localparam logic [7:0] ADDR_SCL_HIGH = 8'hDC;
    localparam logic [7:0] ADDR_SCL_LOW = 8'hDD;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'hE0;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hE4;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'hE8;

    // ----------------------------------------------------------------
    // Field layout and reset values
    // ----------------------------------------------------------------
    localparam int CTL_CLOCK_SOURCE_SELECT_BIT = 0;
    localparam int CTL_FLAG_BIT = 3;
    localparam int CTL_ENABLE_BIT = 6;
    localparam int CODE_LSB = 3;
    localparam int CODE_W = 5;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] SCL_COUNT_RESET = 8'h00;
    localparam logic [4:0] CODE_IDLE = 5'h1F;
    localparam logic [4:0] CODE_LAST_DEFINED = 5'h18;
    localparam int NUM_CODES = 26;
    localparam int IRQ_W = 2;
    localparam int IRQ_FLAG = 0;
    localparam int IRQ_BADCODE = 1;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [7:0] dat;
    } iss_wb_req_t;

    typedef enum logic [1:0] {
        SG_IDLE = 2'b00,
        SG_HIGH = 2'b01,
        SG_LOW = 2'b10
    } iss_sg_state_t;

    // Code 0x1F (F8h) is idle; 0x00..0x18 (00h..C0h) are the 25 defined
    function automatic logic iss_code_defined(input logic [4:0] c);
        return c <= CODE_LAST_DEFINED;
    endfunction

endpackage

// *** src/iss_scl_gen.sv ***
// Serial clock rate generator with internal counts or timer overflow
`timescale 1ns/1ps
module iss_scl_gen
    import iss_pkg::*;
#(
    parameter int CNT_W = 8
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic clock_source_select,
    input wire logic timer_ovf,
    input wire logic [CNT_W-1:0] high_cnt,
    input wire logic [CNT_W-1:0] low_cnt,
    // Output
    output logic scl
);

    typedef struct packed {
        iss_sg_state_t st;
        logic [CNT_W-1:0] cnt;
        logic scl;
    } iss_sg_t;

    iss_sg_t s_r;
    iss_sg_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        if (!run)
        begin
            s_nxt.st = SG_IDLE;
            s_nxt.scl = 1'b1;
            s_nxt.cnt = '0;
        end
        else if (clock_source_select)
        begin
            s_nxt.st = SG_HIGH;
            if (timer_ovf)
                s_nxt.scl = ~s_r.scl;
        end
        else
        begin
            case (s_r.st)
                SG_IDLE:
                begin
                    s_nxt.st = SG_HIGH;
                    s_nxt.scl = 1'b1;
                    s_nxt.cnt = CNT_W'(1);
                end
                SG_HIGH:
                begin
                    // Counts below one would stall, so treat them as one
                    if (s_r.cnt >= high_cnt)
                    begin
                        s_nxt.st = SG_LOW;
                        s_nxt.scl = 1'b0;
                        s_nxt.cnt = CNT_W'(1);
                    end
                    else
                        s_nxt.cnt = s_r.cnt + CNT_W'(1);
                end
                SG_LOW:
                begin
                    if (s_r.cnt >= low_cnt)
                    begin
                        s_nxt.st = SG_HIGH;
                        s_nxt.scl = 1'b1;
                        s_nxt.cnt = CNT_W'(1);
                    end
                    else
                        s_nxt.cnt = s_r.cnt + CNT_W'(1);
                end
                default:
                    s_nxt.st = SG_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_r <= '{st: SG_IDLE, cnt: '0, scl: 1'b1};
        else
            s_r <= s_nxt;
    end

    assign scl = s_r.scl;

endmodule

// *** src/iss_top.sv ***
// Status-code register and SCL rate block with a classic Wishbone slave
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
module iss_top
    import iss_pkg::*;
#(
    parameter int CNT_W = 8
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [0:0] WB_SEL_I,
    input wire logic [7:0] WB_DAT_I,
    output logic [7:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Protocol engine side
    input wire logic STATE_VALID,
    input wire logic [4:0] STATE_CODE,
    input wire logic TIMER1_OVF,
    input wire logic GLOBAL_INT_EN,
    input wire logic IF_INT_EN,
    // Outputs
    output logic SCL_OUT,
    output logic IRQ_REQ,
    output logic IRQ
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] control;
        logic [CNT_W-1:0] scl_high;
        logic [CNT_W-1:0] scl_low;
        logic ack;
        logic [7:0] rdata;
    } iss_top_st_t;

    iss_top_st_t s_r;
    iss_top_st_t s_nxt;

    iss_wb_req_t req;
    logic wr_en;
    logic rd_en;
    logic [IRQ_W-1:0] irq_evt;
    logic [IRQ_W-1:0] irq_clr;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic irq_en_we;
    logic entered;

    assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I,
                   adr: WB_ADR_I, dat: WB_DAT_I};
    // One ack per request; the ack cycle itself is not a new request
    assign wr_en = req.cyc && req.stb && req.we && WB_SEL_I[0] && !s_r.ack;
    assign rd_en = req.cyc && req.stb && !req.we && !s_r.ack;

    // A defined state enters when the engine posts a new non-idle code
    assign entered = STATE_VALID && (STATE_CODE != CODE_IDLE)
        && iss_code_defined(STATE_CODE);

    assign irq_evt[IRQ_FLAG] = entered;
    assign irq_evt[IRQ_BADCODE] = STATE_VALID && !iss_code_defined(STATE_CODE)
        && (STATE_CODE != CODE_IDLE);
    assign irq_clr = (wr_en && req.adr == ADDR_IRQ_CLEAR)
        ? req.dat[IRQ_W-1:0] : '0;
    assign irq_en_we = wr_en && (req.adr == ADDR_IRQ_ENABLE);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ack = req.cyc && req.stb && !s_r.ack;
        if (STATE_VALID)
        begin
            // Low three bits forced to zero
            s_nxt.status = {STATE_CODE, 3'b000};
        end
        if (wr_en)
        begin
            case (req.adr)
                ADDR_CONTROL:
                begin
                    // Flag may only be cleared by software, never set
                    s_nxt.control = req.dat;
                    s_nxt.control[CTL_FLAG_BIT] =
                        s_r.control[CTL_FLAG_BIT]
                        & req.dat[CTL_FLAG_BIT];
                end
                ADDR_SCL_HIGH:
                    s_nxt.scl_high = req.dat[CNT_W-1:0];
                ADDR_SCL_LOW:
                    s_nxt.scl_low = req.dat[CNT_W-1:0];
                default:
                    s_nxt.control = s_nxt.control;
            endcase
        end
        // Entry sets the flag and outranks a same-cycle clear
        if (entered)
            s_nxt.control[CTL_FLAG_BIT] = 1'b1;
        else if (STATE_VALID && STATE_CODE == CODE_IDLE)
            s_nxt.control[CTL_FLAG_BIT] =
                s_nxt.control[CTL_FLAG_BIT];
        s_nxt.rdata = 8'h00;
        if (rd_en)
        begin
            case (req.adr)
                ADDR_CONTROL:
                    s_nxt.rdata = s_r.control;
                ADDR_STATUS:
                    s_nxt.rdata = s_r.status;
                ADDR_SCL_HIGH:
                    s_nxt.rdata = 8'(s_r.scl_high);
                ADDR_SCL_LOW:
                    s_nxt.rdata = 8'(s_r.scl_low);
                ADDR_IRQ_STATUS:
                    s_nxt.rdata = 8'(irq_status);
                ADDR_IRQ_ENABLE:
                    s_nxt.rdata = 8'(irq_enable);
                default:
                    s_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r.status <= STATUS_RESET;
            s_r.control <= CONTROL_RESET;
            s_r.scl_high <= CNT_W'(SCL_COUNT_RESET);
            s_r.scl_low <= CNT_W'(SCL_COUNT_RESET);
            s_r.ack <= 1'b0;
            s_r.rdata <= 8'h00;
        end
        else
            s_r <= s_nxt;
    end

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    iss_scl_gen #(.CNT_W(CNT_W)) u_scl
    (
        .clk(CLK),
        .rst_n(rst_n),
        .run(s_r.control[CTL_ENABLE_BIT]),
        .clock_source_select(s_r.control[CTL_CLOCK_SOURCE_SELECT_BIT]),
        .timer_ovf(TIMER1_OVF),
        .high_cnt(s_r.scl_high),
        .low_cnt(s_r.scl_low),
        .scl(SCL_OUT)
    );

    iss_irq #(.W(IRQ_W)) u_irq
    (
        .clk(CLK),
        .rst_n(rst_n),
        .evt(irq_evt),
        .clr(irq_clr),
        .en_we(irq_en_we),
        .en_wdat(req.dat[IRQ_W-1:0]),
        .status(irq_status),
        .enable(irq_enable),
        .irq(IRQ)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign IRQ_REQ = s_r.control[CTL_FLAG_BIT] && GLOBAL_INT_EN
        && IF_INT_EN;
    assign WB_ACK_O = s_r.ack;
    assign WB_DAT_O = s_r.rdata;

endmodule

// *** verification/iss_engine_model.sv ***
// Model of the bus engine and timer that feed the status block
`timescale 1ns/1ps
module iss_engine_model
(
    // Clock
    input wire logic clk,
    // Engine and timer strobes
    output logic valid,
    output logic [4:0] code,
    output logic ovf
);
    initial
    begin
        valid = 1'b0;
        code = 5'h00;
        ovf = 1'b0;
    end

    // Code is inverted after the post so a stale value is never reused
    task automatic post(input logic [4:0] c);
        valid <= 1'b1;
        code <= c;
        @(posedge clk);
        valid <= 1'b0;
        code <= ~c;
    endtask

    task automatic tick();
        ovf <= 1'b1;
        @(posedge clk);
        ovf <= 1'b0;
    endtask
endmodule

// *** verification/iss_top_sva.sv ***
// Checker of bus handshake, status layout and interrupt request timing
`timescale 1ns/1ps
module iss_top_chk
    import iss_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Wishbone
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [7:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // Engine and interrupt
    input wire logic STATE_VALID,
    input wire logic [4:0] STATE_CODE,
    input wire logic GLOBAL_INT_EN,
    input wire logic IF_INT_EN,
    input wire logic IRQ_REQ
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    property p_ack_once;
        WB_ACK_O |=> !WB_ACK_O;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack held too long");
    property p_ack_resp;
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
    endproperty
    a_ack_resp: assert property (p_ack_resp)
        else $error("request not answered");
    property p_dat_idle;
        !WB_ACK_O |-> WB_DAT_O == 8'h00;
    endproperty
    a_dat_idle: assert property (p_dat_idle)
        else $error("read data outside ack");
    property p_unmapped;
        WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h80 |-> WB_DAT_O == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_stat_low;
        WB_ACK_O && !WB_WE_I && WB_ADR_I == ADDR_STATUS
            |-> WB_DAT_O[2:0] == 3'b000;
    endproperty
    a_stat_low: assert property (p_stat_low)
        else $error("status low bits set");
    property p_irq_gate;
        IRQ_REQ |-> GLOBAL_INT_EN && IF_INT_EN;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("request while disabled");
    property p_flag_set;
        STATE_VALID && STATE_CODE <= CODE_LAST_DEFINED
            ##1 (GLOBAL_INT_EN && IF_INT_EN) [*2] |-> IRQ_REQ;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("state entry left flag clear");
    property p_no_hw_clear;
        $fell(IRQ_REQ) && GLOBAL_INT_EN && IF_INT_EN
            && $past(GLOBAL_INT_EN && IF_INT_EN)
            |-> WB_ACK_O || $past(WB_ACK_O);
    endproperty
    a_no_hw_clear: assert property (p_no_hw_clear)
        else $error("flag cleared without write");
endmodule

bind iss_top iss_top_chk chk
(
    .CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .STATE_VALID(STATE_VALID),
    .STATE_CODE(STATE_CODE), .GLOBAL_INT_EN(GLOBAL_INT_EN),
    .IF_INT_EN(IF_INT_EN), .IRQ_REQ(IRQ_REQ)
);

// *** verification/tb_iss_top.sv ***
// Self-checking bench of status register, interrupt flag and SCL rate
`timescale 1ns/1ps
module tb_iss_top;
    import iss_pkg::*;
    logic clk, rst_n, cyc, we, ack, gie, ife, valid, ovf, scl, irq_req, irq;
    logic [7:0] adr, wdat, rdat, q;
    logic [4:0] code;
    logic sel;
    logic wsel = 1'b1;
    int h, l;
    int num_errors = 0;
    int checks_done = 0;

    iss_top dut
    (
        .CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(cyc),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .STATE_VALID(valid),
        .STATE_CODE(code), .TIMER1_OVF(ovf), .GLOBAL_INT_EN(gie),
        .IF_INT_EN(ife), .SCL_OUT(scl), .IRQ_REQ(irq_req), .IRQ(irq)
    );
    iss_engine_model eng
    (
        .clk(clk), .valid(valid), .code(code), .ovf(ovf)
    );

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        if (num_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic fail_out();
        num_errors++;
        give_verdict();
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
        input logic [7:0] d, output logic [7:0] r);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= wsel;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 100);
        r = rdat;
        cyc <= 1'b0;
        sel <= 1'b0;
        if (n >= 100)
            fail_out();
        repeat (2) @(posedge clk);
    endtask

    // Skips any phase at the other level, then counts cycles until the lvl phase ends
    task automatic meas(input logic lvl, output int n);
        int g;
        g = 0;
        n = 0;
        while (scl !== lvl && g < 600)
        begin
            @(posedge clk);
            g++;
        end
        while (scl === lvl && n < 600)
        begin
            @(posedge clk);
            n++;
        end
        if (g >= 600 || n >= 600)
            fail_out();
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        wb(1'b0, ADDR_STATUS, 8'h00, q);
        check(q, 8'h00);
        wb(1'b1, ADDR_STATUS, 8'hA5, q);
        wb(1'b0, ADDR_STATUS, 8'h00, q);
        check(q, 8'h00);
        wb(1'b0, 8'h80, 8'h00, q);
        check(q, 8'h00);
        // A write without its byte lane must be dropped
        wsel = 1'b0;
        wb(1'b1, ADDR_SCL_HIGH, 8'h07, q);
        wsel = 1'b1;
        wb(1'b0, ADDR_SCL_HIGH, 8'h00, q);
        check(q, 8'h00);
    endtask

    task automatic t_codes();
        wb(1'b1, ADDR_CONTROL, 8'h40, q);
        for (int c = 0; c < 32; c++)
        begin
            if (c > 24 && c != 31)
                continue;
            eng.post(5'(c));
            wb(1'b0, ADDR_STATUS, 8'h00, q);
            check(q, {5'(c), 3'b000});
            check({7'h00, irq_req}, {7'h00, c != 31});
            wb(1'b1, ADDR_CONTROL, 8'h48, q);
            check({7'h00, irq_req}, {7'h00, c != 31});
            wb(1'b1, ADDR_CONTROL, 8'h40, q);
            check({7'h00, irq_req}, 8'h00);
        end
    endtask

    task automatic t_gate();
        gie <= 1'b0;
        eng.post(5'h01);
        @(posedge clk);
        check({7'h00, irq_req}, 8'h00);
        gie <= 1'b1;
        ife <= 1'b0;
        repeat (2) @(posedge clk);
        check({7'h00, irq_req}, 8'h00);
        ife <= 1'b1;
        repeat (2) @(posedge clk);
        check({7'h00, irq_req}, 8'h01);
        wb(1'b1, ADDR_CONTROL, 8'h40, q);
    endtask

    task automatic t_events();
        wb(1'b1, ADDR_IRQ_CLEAR, 8'h03, q);
        eng.post(5'h19);
        wb(1'b0, ADDR_IRQ_STATUS, 8'h00, q);
        check(q, 8'h02);
        check({7'h00, irq}, 8'h00);
        wb(1'b1, ADDR_IRQ_ENABLE, 8'h02, q);
        check({7'h00, irq}, 8'h01);
        wb(1'b1, ADDR_IRQ_ENABLE, 8'h00, q);
        check({7'h00, irq}, 8'h00);
        wb(1'b1, ADDR_IRQ_ENABLE, 8'h02, q);
        wb(1'b1, ADDR_IRQ_CLEAR, 8'h02, q);
        check({7'h00, irq}, 8'h00);
        wb(1'b1, ADDR_CONTROL, 8'h40, q);
    endtask

    task automatic t_scl();
        wb(1'b1, ADDR_SCL_HIGH, 8'h05, q);
        wb(1'b1, ADDR_SCL_LOW, 8'h09, q);
        meas(1'b0, h);
        meas(1'b1, h);
        meas(1'b0, l);
        check(8'(h), 8'h05);
        check(8'(l), 8'h09);
    endtask

    task automatic t_timer();
        logic s;
        wb(1'b1, ADDR_CONTROL, 8'h41, q);
        s = scl;
        repeat (20) @(posedge clk);
        check({7'h00, scl}, {7'h00, s});
        eng.tick();
        repeat (2) @(posedge clk);
        check({7'h00, scl}, {7'h00, ~s});
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        rst_n = 1'b0;
        cyc = 1'b0;
        sel = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 8'h00;
        gie = 1'b1;
        ife = 1'b1;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_codes();
        t_gate();
        t_events();
        t_scl();
        t_timer();
        give_verdict();
    end
endmodule
